// *** hw/acc_cfg.svh ***
// What this block does
// - Compare off: set conversion_complete_flag (bit 7) at each conversion end.
// - Compare on: set the flag at conversion end only when compare is true.
// - Clear the flag on status/control write and on result low byte read.
// - Interrupt asserts while flag set and complete_irq_enable (bit 6) high.
// - Continuous enable (bit 5) low: one conversion per write or hardware trigger.
// - Continuous enable high: conversions repeat after write or hardware trigger.
// - Five-bit channel field, bits 4:0, codes 0 to 23 pick inputs 0 to 23.
// - All-ones channel code turns converter off, no extra conversion follows.
// - Without continuous mode, enter low power when a conversion completes.
// - Async clock selected: keep working in stop3, finish running conversion.
// - In stop3 with async clock: accept hardware triggers and continuous starts.
// - Conversion ending in stop3 sets flag and, if enabled, wakes the system.
// - Entering stop1 or stop2 disables block and returns registers to reset.
// - Resolution selectable 8 or 10 bit, single or continuous, polled or interrupt.
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define ACC_OFS_SC 8'h00
`define ACC_OFS_CFG 8'h04
`define ACC_OFS_CMP 8'h08
`define ACC_OFS_RES 8'h0C
`define ACC_OFS_STAT 8'h10
// ****************************************
// Status/control fields
// ****************************************
`define ACC_SC_CONVERSION_COMPLETE_FLAG 7
`define ACC_SC_COMPLETE_IRQ_ENABLE 6
`define ACC_SC_CONTINUOUS_CONVERT_ENABLE 5
`define ACC_SC_CH_HI 4
`define ACC_CH_OFF 5'h1F
`define ACC_CH_LAST 5'h17
// ****************************************
// Configuration fields
// ****************************************
`define ACC_CFG_MODE10 0
`define ACC_CFG_ASYNC 1
`define ACC_CFG_HWT 2
`define ACC_CFG_DIV_LO 3
`define ACC_CFG_DIV_HI 4
`define ACC_CFG_LONG 5
`define ACC_CFG_RST 8'h00
// ****************************************
// Compare fields
// ****************************************
`define ACC_CMP_EN 0
`define ACC_CMP_GT 1
`define ACC_CMP_VAL_LO 16
`define ACC_CMP_VAL_HI 25
// ****************************************
// Timing in conversion clock ticks
// ****************************************
`define ACC_SAMPLE_SHORT 4'h3
`define ACC_SAMPLE_LONG 4'hF
`define ACC_BITS_8 4'h8
`define ACC_BITS_10 4'hA
`endif

// *** hw/acc_pkg.sv ***
package acc_pkg;
  typedef enum logic [1:0] {AccIdle, AccSample, AccConvert} acc_state_t;
endpackage

// *** hw/acc_conversion_control.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "acc_cfg.svh"
module acc_conversion_control
  import acc_pkg::*;
#(
  parameter int DATA_W = 10,
  parameter int CH_W = 5
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hardwareTrigger,
  input wire logic asyncClockTick,
  input wire logic stop3Mode,
  input wire logic stop12Mode,
  input wire logic [DATA_W-1:0] analogData,
  output logic [CH_W-1:0] inputChannelSelect,
  output logic converterPowerOn,
  output logic sampleEnable,
  output logic conversionIrq,
  output logic wakeRequest
);

  if (DATA_W != 10 || CH_W != 5)
  begin : gBadParams
    $error("acc_conversion_control supports only DATA_W 10 and CH_W 5");
  end

  // ****************************************
  // Register state
  // ****************************************
  logic conversionCompleteFlag_q;
  logic completeIrqEnable_q;
  logic continuousConvertEnable_q;
  logic [CH_W-1:0] channel_q;
  logic [7:0] config_q;
  logic compareEnable_q;
  logic compareGreater_q;
  logic [DATA_W-1:0] compareValue_q;
  logic [DATA_W-1:0] result_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  acc_state_t state_q;
  logic [3:0] tickCount_q;
  logic [2:0] divCount_q;
  logic trigPrev_q;
  logic active_q;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `ACC_OFS_SC) || (a == `ACC_OFS_CFG) || (a == `ACC_OFS_CMP) ||
               (a == `ACC_OFS_RES) || (a == `ACC_OFS_STAT);
  endfunction

  wire logic setupPhase = psel && !penable;
  wire logic accessDone = psel && penable;
  wire logic scWrite = accessDone && pwrite && (paddr == `ACC_OFS_SC);
  wire logic cfgWrite = accessDone && pwrite && (paddr == `ACC_OFS_CFG);
  wire logic cmpWrite = accessDone && pwrite && (paddr == `ACC_OFS_CMP);
  wire logic resRead = accessDone && !pwrite && (paddr == `ACC_OFS_RES);
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && accessDone;

  wire logic hwTriggerMode = config_q[`ACC_CFG_HWT];
  wire logic asyncSelected = config_q[`ACC_CFG_ASYNC];
  wire logic mode10 = config_q[`ACC_CFG_MODE10];
  wire logic channelOff = (channel_q == `ACC_CH_OFF);

  // ****************************************
  // Read data and error, latched at setup
  // ****************************************
  logic [31:0] readMux;
  always_comb
  begin
    readMux = 32'h0000_0000;
    unique case (paddr)
      `ACC_OFS_SC:
        readMux[7:0] = {conversionCompleteFlag_q, completeIrqEnable_q,
                        continuousConvertEnable_q, channel_q};
      `ACC_OFS_CFG:
        readMux[7:0] = config_q;
      `ACC_OFS_CMP:
      begin
        readMux[`ACC_CMP_EN] = compareEnable_q;
        readMux[`ACC_CMP_GT] = compareGreater_q;
        readMux[`ACC_CMP_VAL_HI:`ACC_CMP_VAL_LO] = compareValue_q;
      end
      `ACC_OFS_RES:
        readMux[DATA_W-1:0] = result_q;
      `ACC_OFS_STAT:
        readMux[3:0] = {converterPowerOn, active_q, state_q};
      default:
        readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata_q <= pwrite ? 32'h0000_0000 : readMux;
      pslverr_q <= !isMapped(paddr);
    end
  end

  // ****************************************
  // Conversion clock enable
  // ****************************************
  logic [2:0] divLimit;
  always_comb
  begin
    unique case (config_q[`ACC_CFG_DIV_HI:`ACC_CFG_DIV_LO])
      2'h0: divLimit = 3'h0;
      2'h1: divLimit = 3'h1;
      2'h2: divLimit = 3'h3;
      default: divLimit = 3'h7;
    endcase
  end
  wire logic divTick = (divCount_q == divLimit);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      divCount_q <= 3'h0;
    else if (divTick || stop12Mode)
      divCount_q <= 3'h0;
    else
      divCount_q <= divCount_q + 3'h1;
  end

  // Bus-derived clock stops in stop3, the async one keeps running
  wire logic convTick = asyncSelected ? asyncClockTick : (divTick && !stop3Mode);

  // ****************************************
  // Triggers
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      trigPrev_q <= 1'b0;
    else
      trigPrev_q <= hardwareTrigger;
  end
  wire logic hwEdge = hardwareTrigger && !trigPrev_q;
  wire logic newChOff = (pwdata[`ACC_SC_CH_HI:0] == `ACC_CH_OFF);
  wire logic startReq = hwTriggerMode ? (hwEdge && !channelOff) : (scWrite && !newChOff);

  // ****************************************
  // Conversion sequencer
  // ****************************************
  wire logic [3:0] sampleTicks = config_q[`ACC_CFG_LONG] ? `ACC_SAMPLE_LONG : `ACC_SAMPLE_SHORT;
  wire logic [3:0] bitTicks = mode10 ? `ACC_BITS_10 : `ACC_BITS_8;
  wire logic convDone = (state_q == AccConvert) && convTick && (tickCount_q == bitTicks - 4'h1);
  wire logic [DATA_W-1:0] newResult = mode10 ? analogData : {2'b00, analogData[DATA_W-1:2]};
  wire logic compareTrue = compareGreater_q ? (newResult >= compareValue_q)
                                            : (newResult < compareValue_q);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      active_q <= 1'b0;
    else if (stop12Mode || (scWrite && newChOff) || (channelOff && !scWrite))
      active_q <= 1'b0;
    else if (startReq)
      active_q <= 1'b1;
    else if (convDone && !continuousConvertEnable_q)
      active_q <= 1'b0;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= AccIdle;
      tickCount_q <= 4'h0;
    end
    else if (stop12Mode || (scWrite && newChOff))
    begin
      state_q <= AccIdle;
      tickCount_q <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        AccIdle:
        if (startReq)
        begin
          state_q <= AccSample;
          tickCount_q <= 4'h0;
        end
        AccSample:
        if (convTick)
        begin
          if (tickCount_q == sampleTicks)
          begin
            state_q <= AccConvert;
            tickCount_q <= 4'h0;
          end
          else
            tickCount_q <= tickCount_q + 4'h1;
        end
        AccConvert:
        if (convDone)
        begin
          tickCount_q <= 4'h0;
          // Continuous mode rolls straight into the next sample
          state_q <= (continuousConvertEnable_q && !channelOff) ? AccSample : AccIdle;
        end
        else if (convTick)
          tickCount_q <= tickCount_q + 4'h1;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      result_q <= '0;
    else if (stop12Mode)
      result_q <= '0;
    else if (convDone && (!compareEnable_q || compareTrue))
      result_q <= newResult;
  end

  // ****************************************
  // Complete flag, set wins over clear
  // ****************************************
  wire logic flagSet = convDone && (!compareEnable_q || compareTrue);
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      conversionCompleteFlag_q <= 1'b0;
    else if (stop12Mode)
      conversionCompleteFlag_q <= 1'b0;
    else if (flagSet)
      conversionCompleteFlag_q <= 1'b1;
    else if (scWrite || resRead)
      conversionCompleteFlag_q <= 1'b0;
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      completeIrqEnable_q <= 1'b0;
      continuousConvertEnable_q <= 1'b0;
      channel_q <= `ACC_CH_OFF;
    end
    else if (stop12Mode)
    begin
      completeIrqEnable_q <= 1'b0;
      continuousConvertEnable_q <= 1'b0;
      channel_q <= `ACC_CH_OFF;
    end
    else if (scWrite)
    begin
      completeIrqEnable_q <= pwdata[`ACC_SC_COMPLETE_IRQ_ENABLE];
      continuousConvertEnable_q <= pwdata[`ACC_SC_CONTINUOUS_CONVERT_ENABLE];
      channel_q <= pwdata[`ACC_SC_CH_HI:0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      config_q <= `ACC_CFG_RST;
    else if (stop12Mode)
      config_q <= `ACC_CFG_RST;
    else if (cfgWrite)
      config_q <= pwdata[7:0];
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      compareEnable_q <= 1'b0;
      compareGreater_q <= 1'b0;
      compareValue_q <= '0;
    end
    else if (stop12Mode)
    begin
      compareEnable_q <= 1'b0;
      compareGreater_q <= 1'b0;
      compareValue_q <= '0;
    end
    else if (cmpWrite)
    begin
      compareEnable_q <= pwdata[`ACC_CMP_EN];
      compareGreater_q <= pwdata[`ACC_CMP_GT];
      compareValue_q <= pwdata[`ACC_CMP_VAL_HI:`ACC_CMP_VAL_LO];
    end
  end

  // ****************************************
  // Analog side and interrupt outputs
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      inputChannelSelect <= `ACC_CH_OFF;
      converterPowerOn <= 1'b0;
      sampleEnable <= 1'b0;
    end
    else
    begin
      inputChannelSelect <= (stop12Mode || channel_q > `ACC_CH_LAST) ? `ACC_CH_OFF : channel_q;
      converterPowerOn <= (state_q != AccIdle) && !channelOff && !stop12Mode;
      sampleEnable <= (state_q == AccSample) && !channelOff && !stop12Mode;
    end
  end

  assign conversionIrq = conversionCompleteFlag_q && completeIrqEnable_q;
  assign wakeRequest = conversionIrq && stop3Mode && asyncSelected;

endmodule // acc_conversion_control
`default_nettype wire

// *** dv/acc_analog_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Analog inputs seen by the converter
// ****
module acc_analog_model
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] channel,
  input wire logic powerOn,
  output logic [9:0] level
);
  // Level follows the channel; isolated input shows a changing pattern
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      level <= 10'h155;
    else
      level <= powerOn ? {channel, 5'h0A} : ~level;
endmodule // acc_analog_model
`default_nettype wire

// *** dv/acc_conversion_control_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module acc_conversion_control_assertions
#(
  parameter int DATA_W = 10,
  parameter int CH_W = 5
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hardwareTrigger,
  input wire logic asyncClockTick,
  input wire logic stop3Mode,
  input wire logic stop12Mode,
  input wire logic [DATA_W-1:0] analogData,
  input wire logic [CH_W-1:0] inputChannelSelect,
  input wire logic converterPowerOn,
  input wire logic sampleEnable,
  input wire logic conversionIrq,
  input wire logic wakeRequest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic scWr;
  logic mapped;
  assign scWr = psel && penable && pwrite && paddr == 8'h00 && !stop12Mode;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr) else $error("no error");
  a_err_mapped: assert property (psel && penable && mapped |-> !pslverr) else $error("false error");
  a_wake_gate: assert property (wakeRequest |-> conversionIrq && stop3Mode) else $error("bad wake");
  a_irq_masked: assert property (scWr && !pwdata[6] |=> !conversionIrq) else $error("irq unmasked");
  a_chan_map: assert property (scWr |=> ##1 inputChannelSelect ==
    ($past(pwdata[4:0], 2) > 5'h17 ? 5'h1F : $past(pwdata[4:0], 2))) else $error("bad channel");
  a_off_unpowered: assert property (inputChannelSelect == 5'h1F |-> !converterPowerOn) else $error("powered");
  a_off_stays: assert property (scWr && pwdata[4:0] == 5'h1F |=> ##1 (!sampleEnable)[*3]) else $error("restart");
  a_sample_powered: assert property (sampleEnable |-> converterPowerOn) else $error("unpowered");
  a_stop12_reset: assert property (stop12Mode |=> !conversionIrq && !converterPowerOn
    && inputChannelSelect == 5'h1F) else $error("no reset");
  c_irq: cover property ($rose(conversionIrq));
  c_wake: cover property (wakeRequest);
  c_err: cover property (psel && penable && pslverr);
  c_stop3: cover property (sampleEnable && stop3Mode);
endmodule // acc_conversion_control_assertions
bind acc_conversion_control acc_conversion_control_assertions #(.DATA_W(DATA_W), .CH_W(CH_W)) chk_u (.*);
`default_nettype wire

// *** dv/tb_acc_conversion_control.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench
// ****
module tb_acc_conversion_control;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic hardwareTrigger = 0, asyncClockTick = 0, stop3Mode = 0, stop12Mode = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, converterPowerOn, sampleEnable, conversionIrq, wakeRequest;
  logic [9:0] analogData;
  logic [4:0] inputChannelSelect, ch;
  int miscompares = 0, check_count = 0, seed = 32'hA0670F50, i;
  acc_conversion_control #(.DATA_W(10), .CH_W(5)) dut_u (.*);
  acc_analog_model model_u (.clock(clock), .sys_rst(sys_rst), .channel(inputChannelSelect),
    .powerOn(converterPowerOn), .level(analogData));
  always #2 clock = ~clock;
  always @(posedge clock) asyncClockTick <= 1'($random(seed));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bail();
    miscompares++;
    conclude();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20)
      bail();
    @(posedge clock);
  endtask
  task automatic waitHi(input bit wake);
    int n;
    n = 0;
    while ((wake ? wakeRequest : conversionIrq) !== 1'b1 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000)
      bail();
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    do
    begin
      apb(0, 8'h10, 0);
      n++;
    end
    while (r[2] !== 1'b0 && n < 300);
    if (n >= 300)
      bail();
  endtask
  function automatic logic [31:0] expRes(input logic [4:0] c);
    return {22'h0, c, 5'h0A};
  endfunction
  task automatic pulse();
    hardwareTrigger <= 1;
    @(posedge clock);
    hardwareTrigger <= 0;
  endtask
  task automatic single(input logic [4:0] c);
    apb(1, 8'h00, {24'h0, 3'b010, c});
    waitHi(0);
    chk("chan", inputChannelSelect, c);
    apb(0, 8'h00, 0);
    chk("sc", r, {24'h0, 3'b110, c});
    apb(0, 8'h0C, 0);
    chk("res", r, expRes(c));
    chk("irq", conversionIrq, 0);
    chk("pwr", converterPowerOn, 0);
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    apb(0, 8'h00, 0);
    chk("scRst", r, 32'h1F);
    apb(0, 8'h14, 0);
    chk("err", e, 1);
    chk("errData", r, 0);
    apb(1, 8'h04, 32'h01);
    single(0);
    single(23);
    for (i = 0; i < 4; i++)
    begin
      ch = 5'($unsigned($random(seed)) % 24);
      single(ch);
    end
    $display("single done");
    apb(1, 8'h00, 32'h05);
    waitIdle();
    chk("mask", conversionIrq, 0);
    apb(0, 8'h00, 0);
    chk("flag", r[7], 1);
    apb(1, 8'h00, 32'h1F);
    apb(0, 8'h00, 0);
    chk("wrClr", r[7], 0);
    apb(1, 8'h08, 32'h03FF0003);
    apb(1, 8'h00, 32'h43);
    waitIdle();
    apb(0, 8'h00, 0);
    chk("cmpF", r[7], 0);
    apb(1, 8'h08, 32'h00000003);
    single(3);
    apb(1, 8'h08, 0);
    $display("compare done");
    apb(1, 8'h00, 32'h67);
    waitHi(0);
    apb(0, 8'h0C, 0);
    chk("cont", r, expRes(7));
    waitHi(0);
    apb(1, 8'h00, 32'h7F);
    @(posedge clock);
    chk("off", converterPowerOn, 0);
    repeat (40) @(posedge clock);
    chk("noExtra", conversionIrq, 0);
    $display("continuous done");
    apb(1, 8'h04, 32'h05);
    apb(1, 8'h00, 32'h49);
    apb(0, 8'h10, 0);
    chk("hwWait", r[2], 0);
    pulse();
    waitHi(0);
    apb(0, 8'h0C, 0);
    chk("hwRes", r, expRes(9));
    apb(1, 8'h04, 32'h07);
    apb(1, 8'h00, 32'h4C);
    pulse();
    stop3Mode <= 1;
    waitHi(1);
    apb(0, 8'h0C, 0);
    chk("s3Res", r, expRes(12));
    pulse();
    waitHi(1);
    stop3Mode <= 0;
    $display("stop3 done");
    apb(1, 8'h08, 32'h3);
    stop12Mode <= 1;
    @(posedge clock);
    stop12Mode <= 0;
    apb(0, 8'h00, 0);
    chk("s12Sc", r, 32'h1F);
    apb(0, 8'h04, 0);
    chk("s12Cfg", r, 0);
    apb(0, 8'h08, 0);
    chk("s12Cmp", r, 0);
    apb(1, 8'h04, 32'h01);
    single(5);
    $display("stop12 done");
    conclude();
  end
endmodule // tb_acc_conversion_control
`default_nettype wire
